// >>> brm_consts.vh
`ifndef BRM_CONSTS_VH
`define BRM_CONSTS_VH
// Behaviour
// R01 - The store takes four shapes: 256x16 with 8-bit addresses and a bit mask, 512x8, 1024x4 and 2048x2 with 9, 10 and 11-bit addresses and no mask.
// R02 - Every shape holds 4 kbit behind one write port and one read port, usable as single, pseudo dual port or FIFO storage.
// R03 - In the default variant writes take the rising write-clock edge and reads the rising read-clock edge.
// R04 - In the read-inverted variant writes take the rising write-clock edge and reads the falling read-clock edge.
// R05 - In the write-inverted variant writes take the falling write-clock edge and reads the rising read-clock edge.
// R06 - In the fully inverted variant writes and reads both take the falling edges of their clocks.
// R07 - The contents can be loaded with initial values during configuration, before user operation.
// R08 - For read-only use the user logic relies on preloaded contents and holds the write controls inactive.
// R09 - Wider or deeper stores are built by user logic from several blocks with address decode and output muxing.
// R10 - FIFO pointers and full and empty tracking are supplied by user logic around the two ports.
// R11 - Write data, write address and read address are registered at the inputs on the active edge in every shape.
// R12 - In the 16-bit shape a mask bit at 0 writes its data bit and a mask bit at 1 keeps the stored bit.
// R13 - A write happens on an active write-clock edge only while write enable and write clock enable are both high.
// R14 - Read data changes only on an active read-clock edge with read enable and read clock enable high, else it holds.

// ==========================================================
// Shapes
`define BRM_SHAPE_256X16   2'h0
`define BRM_SHAPE_512X8    2'h1
`define BRM_SHAPE_1024X4   2'h2
`define BRM_SHAPE_2048X2   2'h3

// ==========================================================
// Clock edge variants
`define BRM_VAR_DEFAULT    2'h0
`define BRM_VAR_RD_INV     2'h1
`define BRM_VAR_WR_INV     2'h2
`define BRM_VAR_ALL_INV    2'h3

// ==========================================================
// Geometry
`define BRM_ROWS           256
`define BRM_ROW_W          8
`define BRM_DATA_W         16
`define BRM_ADDR_W         11

// ==========================================================
// Reset values
`define BRM_RDATA_RST      16'h0000
`define BRM_SYNC_RST       1'b0

`endif

// >>> brm_sync2.v
`timescale 1ns/10ps
`include "brm_consts.vh"
// ==========================================================
// Two-stage synchroniser
module brm_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rstn_i,
    // Data
    input  wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= {WIDTH{`BRM_SYNC_RST}};
            sync_q <= {WIDTH{`BRM_SYNC_RST}};
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

// >>> brm_block_ram.v
`timescale 1ns/10ps
`include "brm_consts.vh"
// ==========================================================
// 4 kbit block_ram with selectable shape and clock edges
module brm_block_ram (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // Configuration
    input  wire [1:0]  shape_i,
    input  wire [1:0]  variant_i,
    input  wire        cfg_load_i,
    input  wire [7:0]  cfg_row_i,
    input  wire [15:0] cfg_data_i,
    // Write port
    input  wire        write_clock_i,
    input  wire        write_clock_enable_i,
    input  wire        write_enable_i,
    input  wire [10:0] write_address_i,
    input  wire [15:0] write_data_i,
    input  wire [15:0] write_mask_i,
    // Read port
    input  wire        read_clock_i,
    input  wire        read_clock_enable_i,
    input  wire        read_enable_i,
    input  wire [10:0] read_address_i,
    output wire [15:0] read_data_o
);
    // ==========================================================
    // Address and lane functions
    function [7:0] row_of;
        input [1:0]  shape;
        input [10:0] addr;
        begin
            case (shape)
                `BRM_SHAPE_256X16: row_of = addr[7:0];
                `BRM_SHAPE_512X8:  row_of = addr[8:1];
                `BRM_SHAPE_1024X4: row_of = addr[9:2];
                default:           row_of = addr[10:3];
            endcase
        end
    endfunction

    function [15:0] lane_bits;
        input [1:0]  shape;
        input [10:0] addr;
        input [15:0] mask;
        begin
            case (shape)
                `BRM_SHAPE_256X16: lane_bits = ~mask; // R12
                `BRM_SHAPE_512X8:  lane_bits = 16'h00ff << {addr[0], 3'h0};
                `BRM_SHAPE_1024X4: lane_bits = 16'h000f << {addr[1:0], 2'h0};
                default:           lane_bits = 16'h0003 << {addr[2:0], 1'b0};
            endcase
        end
    endfunction

    function [15:0] spread;
        input [1:0]  shape;
        input [15:0] data;
        begin
            case (shape)
                `BRM_SHAPE_256X16: spread = data;
                `BRM_SHAPE_512X8:  spread = {2{data[7:0]}};
                `BRM_SHAPE_1024X4: spread = {4{data[3:0]}};
                default:           spread = {8{data[1:0]}};
            endcase
        end
    endfunction

    function [15:0] pick;
        input [1:0]  shape;
        input [10:0] addr;
        input [15:0] word;
        reg   [15:0] sh;
        begin
            sh = 16'h0000;
            case (shape)
                `BRM_SHAPE_256X16: pick = word;
                `BRM_SHAPE_512X8: begin
                    sh   = word >> {addr[0], 3'h0};
                    pick = {8'h00, sh[7:0]};
                end
                `BRM_SHAPE_1024X4: begin
                    sh   = word >> {addr[1:0], 2'h0};
                    pick = {12'h000, sh[3:0]};
                end
                default: begin
                    sh   = word >> {addr[2:0], 1'b0};
                    pick = {14'h0000, sh[1:0]};
                end
            endcase
        end
    endfunction

    function edge_hit;
        input falling;
        input prev;
        input cur;
        begin
            if (falling) begin
                edge_hit = prev & ~cur;
            end else begin
                edge_hit = ~prev & cur;
            end
        end
    endfunction

    // ==========================================================
    // Input synchronisers, clock and its data kept aligned
    wire        wclk_s;
    wire        wce_s;
    wire        we_s;
    wire [10:0] write_address_s;
    wire [15:0] wdata_s;
    wire [15:0] wmask_s;
    wire        rclk_s;
    wire        rce_s;
    wire        re_s;
    wire [10:0] read_address_s;
    wire [1:0]  shape_s;
    wire [1:0]  variant_s;

    brm_sync2 #(.WIDTH(46)) u_wsync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({write_clock_i, write_clock_enable_i, write_enable_i,
                  write_address_i, write_data_i, write_mask_i}),
        .q_o    ({wclk_s, wce_s, we_s, write_address_s, wdata_s, wmask_s})
    );

    brm_sync2 #(.WIDTH(18)) u_rsync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({read_clock_i, read_clock_enable_i, read_enable_i,
                  read_address_i, shape_i, variant_i}),
        .q_o    ({rclk_s, rce_s, re_s, read_address_s, shape_s, variant_s})
    );

    // ==========================================================
    // Edge detection per variant
    reg  wclk_prev_q;
    reg  rclk_prev_q;
    wire wr_falling;
    wire rd_falling;
    wire wr_edge;
    wire rd_edge;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wclk_prev_q <= `BRM_SYNC_RST;
            rclk_prev_q <= `BRM_SYNC_RST;
        end else begin
            wclk_prev_q <= wclk_s;
            rclk_prev_q <= rclk_s;
        end
    end

    assign wr_falling = (variant_s == `BRM_VAR_WR_INV) || (variant_s == `BRM_VAR_ALL_INV); // R05 R06
    assign rd_falling = (variant_s == `BRM_VAR_RD_INV) || (variant_s == `BRM_VAR_ALL_INV); // R04 R06
    assign wr_edge    = edge_hit(wr_falling, wclk_prev_q, wclk_s); // R03
    assign rd_edge    = edge_hit(rd_falling, rclk_prev_q, rclk_s); // R03

    // ==========================================================
    // Input registers, loaded on the active edge
    reg         wr_go_q;
    reg  [7:0]  wr_row_q;
    reg  [15:0] wr_bits_q;
    reg  [15:0] wr_val_q;
    reg         rd_go_q;
    reg  [1:0]  rd_shape_q;
    reg  [10:0] rd_addr_q;
    wire        wr_go;
    wire        rd_go;

    assign wr_go = wr_edge & wce_s & we_s; // R13
    assign rd_go = rd_edge & rce_s & re_s; // R14

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_go_q <= `BRM_SYNC_RST;
            rd_go_q <= `BRM_SYNC_RST;
        end else begin
            wr_go_q <= wr_go;
            rd_go_q <= rd_go;
        end
    end

    always @(posedge clk_i) begin
        if (wr_go) begin
            wr_row_q  <= row_of(shape_s, write_address_s); // R01 R11
            wr_bits_q <= lane_bits(shape_s, write_address_s, wmask_s);
            wr_val_q  <= spread(shape_s, wdata_s);
        end
        if (rd_go) begin
            rd_shape_q <= shape_s;
            rd_addr_q  <= read_address_s; // R11
        end
    end

    // ==========================================================
    // Storage, 256 rows of 16 bits in every shape
    reg  [15:0] mem_q [0:`BRM_ROWS-1]; // R02

    always @(posedge clk_i) begin
        if (cfg_load_i) begin
            mem_q[cfg_row_i] <= cfg_data_i; // R07
        end else if (wr_go_q) begin
            mem_q[wr_row_q] <= (mem_q[wr_row_q] & ~wr_bits_q) | (wr_val_q & wr_bits_q); // R12
        end
    end

    // ==========================================================
    // Read port
    reg  [15:0] rdata_q;
    wire [15:0] rd_word;

    assign rd_word = mem_q[row_of(rd_shape_q, rd_addr_q)];

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= `BRM_RDATA_RST;
        end else if (rd_go_q) begin
            rdata_q <= pick(rd_shape_q, rd_addr_q, rd_word); // R14
        end
    end

    assign read_data_o = rdata_q;
endmodule

// >>> brm_block_ram_dummy_unused.v
`timescale 1ns/10ps

// >>> brm_block_ram_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Read port checker
module brm_chk (
    input wire        clk_i,
    input wire        rstn_i,
    input wire [1:0]  shape_i,
    input wire [1:0]  variant_i,
    input wire        read_clock_i,
    input wire        read_clock_enable_i,
    input wire        read_enable_i,
    input wire [15:0] read_data_o
);
    reg [4:0] clk_q;
    reg [4:0] en_q;
    reg [4:0] ce_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    always @(posedge clk_i) begin
        clk_q <= {clk_q[3:0], read_clock_i};
        en_q  <= {en_q[3:0], read_enable_i};
        ce_q  <= {ce_q[3:0], read_clock_enable_i};
    end
    rd_en_a: assert property ($changed(read_data_o) |-> |en_q[4:1]) else $error("rd moved, no enable");
    rd_ce_a: assert property ($changed(read_data_o) |-> |ce_q[4:1]) else $error("rd moved, no clk en");
    rd_once_a: assert property ($changed(read_data_o) |=> $stable(read_data_o)) else $error("rd moved twice");
    rd_rise_a: assert property ($changed(read_data_o) && !variant_i[0] |-> |(clk_q[3:0] & ~clk_q[4:1]))
        else $error("rd without rising edge");
    rd_fall_a: assert property ($changed(read_data_o) && variant_i[0] |-> |(~clk_q[3:0] & clk_q[4:1]))
        else $error("rd without falling edge");
    byte_top_a: assert property (shape_i == 2'h1 && $changed(read_data_o) |-> read_data_o[15:8] == 8'h00)
        else $error("byte shape upper bits set");
    nib_top_a: assert property (shape_i == 2'h2 && $changed(read_data_o) |-> read_data_o[15:4] == 12'h000)
        else $error("nibble shape upper bits set");
    pair_top_a: assert property (shape_i == 2'h3 && $changed(read_data_o) |-> read_data_o[15:2] == 14'h0000)
        else $error("pair shape upper bits set");
    cover property ($changed(read_data_o) && shape_i == 2'h0);
    cover property ($changed(read_data_o) && variant_i == 2'h3);
    cover property ($changed(read_data_o) && shape_i == 2'h3);
endmodule
bind brm_block_ram brm_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .shape_i(shape_i), .variant_i(variant_i),
    .read_clock_i(read_clock_i), .read_clock_enable_i(read_clock_enable_i), .read_enable_i(read_enable_i),
    .read_data_o(read_data_o));

// >>> brm_user_model.sv
`timescale 1ns/10ps
// ==========================================================
// Fabric user logic on both ports
module brm_user_model (
    // Clock
    input wire clk_i
);
    reg        w_clk = 1'b0, w_ce = 1'b0, w_en = 1'b0, r_clk = 1'b0, r_ce = 1'b0, r_en = 1'b0;
    reg [1:0]  v     = 2'h0;
    reg [10:0] w_adr = 11'h000, r_adr = 11'h000;
    reg [15:0] w_dat = 16'h0000, w_msk = 16'h0000;
    task cyc(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    // ==========================================================
    // Idle levels follow the edge variant, enables low
    task setv(input [1:0] nv);
        begin
            {v, w_clk, r_clk} = {nv, nv[1], nv[0]};
            cyc(6);
        end
    endtask
    // ==========================================================
    // One write, then controls released and lines scrambled
    task wr(input [10:0] a, input [15:0] d, input [15:0] m, input [1:0] en);
        begin
            {w_adr, w_dat, w_msk, w_ce, w_en} = {a, d, m, en};
            cyc(2);
            w_clk = ~w_clk;
            cyc(4);
            w_clk = ~w_clk;
            {w_adr, w_dat, w_msk, w_ce, w_en} = {~w_adr, ~w_dat, ~w_msk, 2'b00};
            cyc(4);
        end
    endtask
    // ==========================================================
    // One read
    task rd(input [10:0] a, input [1:0] en);
        begin
            {r_adr, r_ce, r_en} = {a, en};
            cyc(2);
            r_clk = ~r_clk;
            cyc(4);
            r_clk = ~r_clk;
            {r_adr, r_ce, r_en} = {~r_adr, 2'b00};
            cyc(4);
        end
    endtask
endmodule

// >>> tb.sv
`timescale 1ns/10ps
// ==========================================================
// Bench with a behavioural memory model
module tb;
    reg         clk_i  = 1'b0;
    reg         rstn_i = 1'b0;
    reg         cl     = 1'b0;
    reg  [1:0]  sh     = 2'h0;
    reg  [7:0]  cr     = 8'h00;
    reg  [15:0] cd     = 16'h0000, d, m, x, last = 16'h0000;
    reg  [10:0] a, b;
    reg  [5:0]  e;
    reg  [63:0] rnd;
    reg  [10:0] wp     = 11'h000, rp = 11'h000;
    reg         bank   = 1'b0;
    reg  [15:0] fq [$];
    reg  [15:0] mem [0:255];
    wire [15:0] rdo, rdo_b;
    wire [15:0] rdm    = bank ? rdo_b : rdo;
    integer     mismatches = 0, checks = 0, seed = 32'hd8e17ddf, cyc_n = 0, i, s, v;
    always #2 clk_i = ~clk_i;
    brm_user_model u_usr (.clk_i(clk_i));
    brm_block_ram u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .shape_i(sh), .variant_i(u_usr.v), .cfg_load_i(cl),
        .cfg_row_i(cr), .cfg_data_i(cd), .write_clock_i(u_usr.w_clk), .write_clock_enable_i(u_usr.w_ce),
        .write_enable_i(u_usr.w_en & ~bank), .write_address_i(u_usr.w_adr), .write_data_i(u_usr.w_dat),
        .write_mask_i(u_usr.w_msk), .read_clock_i(u_usr.r_clk), .read_clock_enable_i(u_usr.r_ce),
        .read_enable_i(u_usr.r_en), .read_address_i(u_usr.r_adr), .read_data_o(rdo));
    brm_block_ram u_dut_b (.clk_i(clk_i), .rstn_i(rstn_i), .shape_i(sh), .variant_i(u_usr.v), .cfg_load_i(cl),
        .cfg_row_i(cr), .cfg_data_i(cd), .write_clock_i(u_usr.w_clk), .write_clock_enable_i(u_usr.w_ce),
        .write_enable_i(u_usr.w_en & bank), .write_address_i(u_usr.w_adr), .write_data_i(u_usr.w_dat),
        .write_mask_i(u_usr.w_msk), .read_clock_i(u_usr.r_clk), .read_clock_enable_i(u_usr.r_ce),
        .read_enable_i(u_usr.r_en), .read_address_i(u_usr.r_adr), .read_data_o(rdo_b));
    // ==========================================================
    // Model access: optional masked write, lane read into x
    task mdl(input [10:0] ad, input wr);
        integer w, l, k, r;
        begin
            w = 16 >> sh;
            r = (ad & ((256 << sh) - 1)) >> sh;
            l = (ad & ((1 << sh) - 1)) * w;
            x = 16'h0000;
            for (k = 0; k < w; k = k + 1) begin
                if (wr && (sh != 2'h0 || !m[k])) mem[r][l + k] = d[k];
                x[k] = mem[r][l + k];
            end
        end
    endtask
    task cmp(input [15:0] exp);
        begin
            checks = checks + 1;
            if (rdm !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] read_data exp %h seen %h", exp, rdm);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 6000) begin
            mismatches = mismatches + 1;
            print_verdict;
        end
    end
    // ==========================================================
    // Preload, then random traffic in every variant and shape
    initial begin
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        @(negedge clk_i);
        for (i = 0; i < 256; i = i + 1) begin
            cl = 1'b1;
            cr = i[7:0];
            rnd = {$random(seed), $random(seed)};
            cd = rnd[15:0];
            mem[i] = cd;
            @(negedge clk_i);
        end
        cl = 1'b0;
        for (v = 0; v < 4; v = v + 1) begin
            u_usr.setv(v[1:0]);
            for (s = 0; s < 4; s = s + 1) begin
                sh = s[1:0];
                u_usr.cyc(6);
                for (i = 0; i < 6; i = i + 1) begin
                    rnd = {$random(seed), $random(seed)};
                    {a, b, d, m, e} = rnd[59:0];
                    u_usr.wr(a, d, m, e[1:0] | {2{e[5]}});
                    mdl(a, (e[1:0] | {2{e[5]}}) == 2'h3);
                    if (i[0]) b = a;
                    mdl(b, 1'b0);
                    u_usr.rd(b, e[3:2] | {2{e[4]}});
                    if ((e[3:2] | {2{e[4]}}) == 2'h3) last = x;
                    cmp(last);
                end
            end
        end
        // ==========================================================
        // FIFO use: pointers and fill count live in the user logic
        sh = 2'h0;
        m  = 16'h0000;
        u_usr.cyc(6);
        for (i = 0; i < 8; i = i + 1) begin
            rnd = {$random(seed), $random(seed)};
            d   = rnd[15:0];
            if (i < 4 && fq.size() < 4) begin
                u_usr.wr(wp, d, m, 2'h3);
                mdl(wp, 1'b1);
                fq.push_back(d);
                wp = wp + 11'h001;
            end else if (fq.size() > 0) begin
                u_usr.rd(rp, 2'h3);
                cmp(fq.pop_front());
                rp = rp + 11'h001;
            end
        end
        // ==========================================================
        // Deeper store from two blocks: bank bit decodes writes and muxes reads
        for (i = 0; i < 2; i = i + 1) begin
            rnd  = {$random(seed), $random(seed)};
            a    = rnd[10:0];
            d    = rnd[31:16];
            bank = 1'b1;
            u_usr.wr(a, d, m, 2'h3);
            u_usr.rd(a, 2'h3);
            cmp(d);
            bank = 1'b0;
            mdl(a, 1'b0);
            u_usr.rd(a, 2'h3);
            cmp(x);
        end
        print_verdict;
    end
endmodule
